// File: design/exec_pkg.sv
package exec_pkg;
   // apb register map, byte addresses, one word each
   localparam logic [7:0]  CTRL_ADDR      = 8'h00;
   localparam logic [7:0]  STAT_ADDR      = 8'h04;
   localparam logic [7:0]  FLAGS_ADDR     = 8'h08;
   localparam logic [7:0]  COUNT_ADDR     = 8'h0C;
   localparam logic [1:0]  RF_WIN         = 2'h1;
   // field positions
   localparam int          CTRL_RUN_BIT   = 0;
   localparam int          CTRL_CLR_BIT   = 1;
   localparam int          STAT_BUSY_BIT  = 0;
   localparam int          STAT_FAULT_BIT = 1;
   localparam int          STAT_FENCE_BIT = 2;
   localparam int          STAT_RSVD_BIT  = 3;
   localparam int          FLAGS_LSB      = 28;
   localparam logic        CTRL_RUN_RST   = 1'b0;
   // fixed register roles and load stride
   localparam logic [3:0]  SP_IDX         = 4'hD;
   localparam logic [31:0] WORD_STEP      = 32'h00000004;
   // opcode patterns of the sixteen-bit forms
   localparam logic [9:0]  OPC_CMP_LO     = 10'h10A;
   localparam logic [7:0]  OPC_CMP_HI     = 8'h45;
   localparam logic [7:0]  OPC_MOV        = 8'h46;
   localparam logic [9:0]  OPC_EOR        = 10'h101;
   localparam logic [4:0]  OPC_LDM        = 5'h19;
   localparam logic [4:0]  OPC_LDR_RN     = 5'h0D;
   localparam logic [4:0]  OPC_LDR_SP     = 5'h13;
   // barrier forms: first halfword, then second halfword bits 15:4
   localparam logic [15:0] OPC_BAR_HW1    = 16'hF3BF;
   localparam logic [11:0] OPC_DSB        = 12'h8F4;
   localparam logic [11:0] OPC_DMB        = 12'h8F5;
   localparam logic [11:0] OPC_ISB        = 12'h8F6;
   // full-system option codes
   localparam logic [3:0]  OPT_SYS4       = 4'hF;
   localparam logic [2:0]  OPT_SYS3       = 3'h7;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } flags_s;

   typedef struct packed {
      logic        valid;
      logic        is32;
      logic        in_it;
      logic [31:0] data;
   } instr_s;

   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
   } mem_req_s;

   typedef struct packed {
      logic        valid;
      logic        err;
      logic [31:0] data;
   } mem_rsp_s;
endpackage

// File: design/add_with_carry.sv
`timescale 1ns/1ps
module add_with_carry
(
   input  wire logic [31:0] a,
   input  wire logic [31:0] b,
   input  wire logic        cin,
   output logic      [31:0] sum,
   output logic             carry,
   output logic             ovf
);
   logic [32:0] wide;

   // 33-bit sum gives the carry out; sign rule gives overflow
   always_comb
   begin
      wide  = {1'b0, a} + {1'b0, b} + {32'h00000000, cin};
      sum   = wide[31:0];
      carry = wide[32];
      ovf   = (a[31] == b[31]) && (sum[31] != a[31]);
   end
endmodule

// File: design/lowest_set8.sv
`timescale 1ns/1ps
module lowest_set8
(
   input  wire logic [7:0] bits,
   output logic      [2:0] idx
);
   // scan downward so the lowest set bit is written last
   always_comb
   begin
      idx = 3'h0;
      for (int i = 7; i >= 0; i--)
      begin
         if (bits[i])
            idx = i[2:0];
      end
   end
endmodule

// File: design/exec_core.sv
`timescale 1ns/1ps
module exec_core
   import exec_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire instr_s      instr,
   output logic             instr_ready,
   output mem_req_s         mem_req,
   input  wire logic        mem_req_ready,
   input  wire mem_rsp_s    mem_rsp,
   input  wire logic        mem_idle,
   input  wire logic        maint_busy,
   output logic             fetch_flush,
   output logic             fatal_fault
);
   typedef enum {S_IDLE, S_REQ, S_RSP, S_SYNC, S_FLUSH} state_e;

   state_e      state;
   state_e      next_state;
   logic [31:0] rf [16];
   flags_s      flags;
   flags_s      next_flags;
   logic [7:0]  list;
   logic [7:0]  next_list;
   logic [2:0]  base;
   logic [2:0]  next_base;
   logic        wback;
   logic        next_wback;
   logic [31:0] addr;
   logic [31:0] next_addr;
   logic        fence;
   logic        next_fence;
   logic        fault;
   logic        next_fault;
   logic        rsvd;
   logic        next_rsvd;
   logic        run;
   logic        next_run;
   logic [31:0] count;
   logic [31:0] next_count;
   logic        next_flush;
   logic        next_fatal;
   logic [31:0] next_prdata;
   logic        next_slverr;
   logic [15:0] hw;
   logic        accept;
   logic        bar32;
   logic        hi_form;
   logic        acc_cmp;
   logic        acc_mov;
   logic        acc_eor;
   logic        acc_ldm;
   logic        acc_ldr_rn;
   logic        acc_ldr_sp;
   logic        acc_dmb;
   logic        acc_dsb;
   logic        acc_isb;
   logic [3:0]  ra;
   logic [3:0]  rb;
   logic [31:0] op_a;
   logic [31:0] op_b;
   logic [31:0] diff;
   logic        c_out;
   logic        v_out;
   logic [2:0]  ld_idx;
   logic        req_v;
   logic        rf_we;
   logic [3:0]  rf_wa;
   logic [31:0] rf_wd;
   logic        apb_setup;
   logic        apb_wr;
   logic        in_win;

   // decode; one issue at a time so older work is always retired
   assign hw         = instr.data[15:0];
   assign accept     = instr.valid && instr_ready;
   assign bar32      = instr.is32 && instr.data[31:16] == OPC_BAR_HW1;
   assign hi_form    = hw[15:8] == OPC_CMP_HI || hw[15:8] == OPC_MOV;
   assign acc_cmp    = accept && !instr.is32
                       && (hw[15:6] == OPC_CMP_LO || hw[15:8] == OPC_CMP_HI);
   assign acc_mov    = accept && !instr.is32 && hw[15:8] == OPC_MOV;
   assign acc_eor    = accept && !instr.is32 && hw[15:6] == OPC_EOR;
   assign acc_ldm    = accept && !instr.is32 && hw[15:11] == OPC_LDM;
   assign acc_ldr_rn = accept && !instr.is32 && hw[15:11] == OPC_LDR_RN;
   assign acc_ldr_sp = accept && !instr.is32 && hw[15:11] == OPC_LDR_SP;
   // option bits do not take part: all codes are full-system
   assign acc_dmb    = accept && bar32 && hw[15:4] == OPC_DMB;
   assign acc_dsb    = accept && bar32 && hw[15:4] == OPC_DSB;
   assign acc_isb    = accept && bar32 && hw[15:4] == OPC_ISB;

   // high form reaches r8..r15, so sp works on either side
   assign ra   = hi_form ? {hw[7], hw[2:0]} : {1'b0, hw[2:0]};
   assign rb   = hi_form ? hw[6:3] : {1'b0, hw[5:3]};
   assign op_a = rf[ra];
   assign op_b = rf[rb];

   // compare is a + ~b + 1 with the sum thrown away
   add_with_carry u_add
   (
      .a     (op_a),
      .b     (~op_b),
      .cin   (1'b1),
      .sum   (diff),
      .carry (c_out),
      .ovf   (v_out)
   );

   lowest_set8 u_scan
   (
      .bits (list),
      .idx  (ld_idx)
   );

   // handshake outputs
   assign instr_ready  = run && state == S_IDLE;
   assign mem_req      = '{valid: req_v, addr: addr};
   assign pready       = 1'b1;

   // execution state machine and register-file write port
   always_comb
   begin
      next_state = state;
      next_flags = flags;
      next_list  = list;
      next_base  = base;
      next_wback = wback;
      next_addr  = addr;
      next_fence = fence;
      next_fault = fault;
      next_rsvd  = rsvd;
      next_count = count;
      next_flush = 1'b0;
      next_fatal = 1'b0;
      req_v      = 1'b0;
      rf_we      = 1'b0;
      rf_wa      = ra;
      rf_wd      = op_b;
      case (state)
         S_IDLE:
         begin
            if (acc_cmp)
            begin
               next_flags = '{n: diff[31], z: diff == 32'h00000000,
                              c: c_out, v: v_out};
               next_count = count + 32'h00000001;
            end
            else if (acc_mov)
            begin
               rf_we      = 1'b1;
               next_count = count + 32'h00000001;
            end
            else if (acc_eor)
            begin
               rf_we = 1'b1;
               rf_wd = op_a ^ op_b;
               // inside a conditional block the flags stay put
               if (!instr.in_it)
               begin
                  next_flags.n = rf_wd[31];
                  next_flags.z = rf_wd == 32'h00000000;
                  next_flags.c = flags.c; // zero shift keeps carry
               end
               next_count = count + 32'h00000001;
            end
            else if (acc_ldm)
            begin
               next_list  = hw[7:0];
               next_base  = hw[10:8];
               next_wback = !hw[hw[10:8]];
               next_addr  = rf[{1'b0, hw[10:8]}];
               next_state = S_REQ;
            end
            else if (acc_ldr_rn)
            begin
               next_list  = 8'h01 << hw[2:0];
               next_wback = 1'b0;
               next_addr  = rf[{1'b0, hw[5:3]}]
                            + {25'h0000000, hw[10:6], 2'b00};
               next_state = S_REQ;
            end
            else if (acc_ldr_sp)
            begin
               next_list  = 8'h01 << hw[10:8];
               next_wback = 1'b0;
               next_addr  = rf[SP_IDX]
                            + {22'h000000, hw[7:0], 2'b00};
               next_state = S_REQ;
            end
            else if (acc_dmb)
            begin
               // only a fence: plain instructions carry on at once
               next_fence = 1'b1;
               next_rsvd  = rsvd || hw[3:0] != OPT_SYS4;
               next_count = count + 32'h00000001;
            end
            else if (acc_dsb)
            begin
               next_rsvd  = rsvd || hw[3:0] != {1'b1, OPT_SYS3};
               next_state = S_SYNC;
            end
            else if (acc_isb)
            begin
               next_rsvd  = rsvd || hw[3:0] != OPT_SYS4;
               next_flush = 1'b1;
               next_state = S_FLUSH;
            end
         end
         S_REQ:
         begin
            if (list == 8'h00)
            begin
               rf_we      = wback;
               rf_wa      = {1'b0, base};
               rf_wd      = addr;
               next_count = count + 32'h00000001;
               next_state = S_IDLE;
            end
            // a pending fence holds the next access until all drained
            else if (!fence || mem_idle)
            begin
               req_v = 1'b1;
               if (mem_req_ready)
               begin
                  next_fence = 1'b0;
                  next_state = S_RSP;
               end
            end
         end
         S_RSP:
         begin
            if (mem_rsp.valid && mem_rsp.err)
            begin
               next_fatal = 1'b1;
               next_fault = 1'b1;
               next_list  = 8'h00;
               next_state = S_IDLE;
            end
            else if (mem_rsp.valid)
            begin
               rf_we      = 1'b1;
               rf_wa      = {1'b0, ld_idx};
               rf_wd      = mem_rsp.data;
               next_list  = list & ~(8'h01 << ld_idx);
               next_addr  = addr + WORD_STEP;
               next_state = S_REQ;
            end
         end
         S_SYNC:
         begin
            // nothing issues until memory and maintenance are quiet
            if (mem_idle && !maint_busy)
            begin
               next_fence = 1'b0;
               next_count = count + 32'h00000001;
               next_state = S_IDLE;
            end
         end
         S_FLUSH:
         begin
            // earlier context writes retired before this point
            next_count = count + 32'h00000001;
            next_state = S_IDLE;
         end
         default:
            next_state = S_IDLE;
      endcase
      if (apb_wr && paddr == CTRL_ADDR && pwdata[CTRL_CLR_BIT]
          && !next_fatal)
         next_fault = 1'b0;
      // core flag update wins over a software write in the same cycle
      if (apb_wr && paddr == FLAGS_ADDR && !acc_cmp
          && !(acc_eor && !instr.in_it))
         next_flags = flags_s'(pwdata[FLAGS_LSB +: 4]);
   end

   // apb slave: read data latched in setup, zero wait states
   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pwrite;
   assign in_win    = paddr[7:6] == RF_WIN && paddr[1:0] == 2'b00;

   always_comb
   begin
      next_prdata = prdata;
      next_slverr = pslverr;
      next_run    = run;
      if (apb_setup)
      begin
         next_slverr = 1'b0;
         next_prdata = 32'h00000000;
         case (paddr)
            CTRL_ADDR:
               next_prdata[CTRL_RUN_BIT] = run;
            STAT_ADDR:
            begin
               next_prdata[STAT_BUSY_BIT]  = state != S_IDLE;
               next_prdata[STAT_FAULT_BIT] = fault;
               next_prdata[STAT_FENCE_BIT] = fence;
               next_prdata[STAT_RSVD_BIT]  = rsvd;
            end
            FLAGS_ADDR:
               next_prdata[FLAGS_LSB +: 4] = flags;
            COUNT_ADDR:
               next_prdata = count;
            default:
            begin
               if (in_win)
                  next_prdata = rf[paddr[5:2]];
               else
                  next_slverr = 1'b1;
            end
         endcase
      end
      if (apb_wr && paddr == CTRL_ADDR)
         next_run = pwdata[CTRL_RUN_BIT];
   end

   // state registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state       <= S_IDLE;
         flags       <= '0;
         list        <= 8'h00;
         base        <= 3'h0;
         wback       <= 1'b0;
         addr        <= 32'h00000000;
         fence       <= 1'b0;
         fault       <= 1'b0;
         rsvd        <= 1'b0;
         run         <= CTRL_RUN_RST;
         count       <= 32'h00000000;
         fetch_flush <= 1'b0;
         fatal_fault <= 1'b0;
         prdata      <= 32'h00000000;
         pslverr     <= 1'b0;
      end
      else
      begin
         state       <= next_state;
         flags       <= next_flags;
         list        <= next_list;
         base        <= next_base;
         wback       <= next_wback;
         addr        <= next_addr;
         fence       <= next_fence;
         fault       <= next_fault;
         rsvd        <= next_rsvd;
         run         <= next_run;
         count       <= next_count;
         fetch_flush <= next_flush;
         fatal_fault <= next_fatal;
         prdata      <= next_prdata;
         pslverr     <= next_slverr;
      end
   end

   // register file; core write beats a software write that cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < 16; i++)
            rf[i] <= 32'h00000000;
      end
      else if (rf_we)
         rf[rf_wa] <= rf_wd;
      else if (apb_wr && in_win)
         rf[paddr[5:2]] <= pwdata;
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_cmp;
      acc_cmp |=> flags.z == ($past(op_a) == $past(op_b))
                  && flags.c == ($past(op_a) >= $past(op_b));
   endproperty
   a_cmp: assert property (p_cmp)
      else $error("compare flags do not match operands");

   property p_cmp_sp;
      acc_cmp && rb == SP_IDX |-> !rf_we ##1 state == S_IDLE;
   endproperty
   a_cmp_sp: assert property (p_cmp_sp)
      else $error("compare with stack pointer disturbed state");

   property p_mov;
      acc_mov |=> rf[$past(ra)] == $past(op_b) && !fatal_fault;
   endproperty
   a_mov: assert property (p_mov)
      else $error("register move did not copy");

   property p_fence;
      fence && !mem_idle |-> !mem_req.valid;
   endproperty
   a_fence: assert property (p_fence)
      else $error("access issued across ordering fence");

   property p_dmb_go;
      acc_dmb |=> instr_ready == run && fence;
   endproperty
   a_dmb_go: assert property (p_dmb_go)
      else $error("ordering barrier stalled the core");

   property p_dsb;
      state == S_SYNC && (maint_busy || !mem_idle) |=> state == S_SYNC;
   endproperty
   a_dsb: assert property (p_dsb)
      else $error("sync barrier released too early");

   property p_xor_v;
      acc_eor |=> flags.v == $past(flags.v)
                  && rf[$past(ra)] == ($past(op_a) ^ $past(op_b));
   endproperty
   a_xor_v: assert property (p_xor_v)
      else $error("xor result or overflow wrong");

   property p_xor_it;
      acc_eor && instr.in_it |=> $stable(flags);
   endproperty
   a_xor_it: assert property (p_xor_it)
      else $error("xor changed flags inside conditional block");

   property p_isb;
      acc_isb |=> fetch_flush && !instr_ready ##1 !fetch_flush;
   endproperty
   a_isb: assert property (p_isb)
      else $error("fetch barrier flush pulse wrong");

   property p_step;
      state == S_RSP && mem_rsp.valid && !mem_rsp.err
         |=> addr == $past(addr) + WORD_STEP;
   endproperty
   a_step: assert property (p_step)
      else $error("load address did not step by one word");

   property p_ldr_sp;
      acc_ldr_sp |=> addr == $past(rf[SP_IDX])
                     + {22'h000000, $past(hw[7:0]), 2'b00};
   endproperty
   a_ldr_sp: assert property (p_ldr_sp)
      else $error("stack pointer load address wrong");

   property p_fault;
      state == S_RSP && mem_rsp.valid && mem_rsp.err
         |=> fatal_fault && state == S_IDLE ##1 !fatal_fault;
   endproperty
   a_fault: assert property (p_fault)
      else $error("failed access did not raise fatal fault");
endmodule

// File: tb/mem_model.sv
`timescale 1ns/1ps
module mem_model
   import exec_pkg::*;
(
   input  wire logic     pclk,
   input  wire logic     presetn,
   input  wire mem_req_s mem_req,
   output logic          mem_req_ready,
   output mem_rsp_s      mem_rsp,
   output logic          mem_idle
);
   int          seed = 35136;
   int          wait_n;
   int          drain;
   logic        busy;
   logic [31:0] addr;

   // posted traffic keeps the system busy a while after each answer
   assign mem_idle = !busy && drain == 0;

   // random accept and answer delays exercise every memory wait of the core
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         mem_req_ready <= 1'b0;
         mem_rsp       <= '0;
         busy          <= 1'b0;
         wait_n        <= 0;
         drain         <= 0;
         addr          <= '0;
      end
      else
      begin
         mem_req_ready <= !busy && $random(seed) & 1;
         if (busy && wait_n == 0)
         begin
            busy    <= 1'b0;
            drain   <= 8 + ($random(seed) & 7);
            // region 0xE (address bits 31:28) refuses the access
            mem_rsp <= {1'b1, addr[31:28] == 4'hE, addr ^ 32'h5A5AC3C3};
         end
         else
         begin
            // released data keeps toggling so stale values never match
            mem_rsp <= {1'b0, 1'b0, ~mem_rsp.data};
            if (drain > 0)
               drain <= drain - 1;
            if (busy)
               wait_n <= wait_n - 1;
            else if (mem_req.valid && mem_req_ready)
            begin
               busy   <= 1'b1;
               addr   <= mem_req.addr;
               wait_n <= $random(seed) & 3;
            end
         end
      end
endmodule

// File: tb/cmp_barrier_xor_load_exec_test.sv
`timescale 1ns/1ps
module cmp_barrier_xor_load_exec_test
   import exec_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   instr_s      instr = '0;
   logic        instr_ready;
   mem_req_s    mem_req;
   logic        mem_req_ready;
   mem_rsp_s    mem_rsp;
   logic        mem_idle;
   logic        maint_busy = 1'b0;
   logic        fetch_flush;
   logic        fatal_fault;
   int          err_count = 0;
   int          check_count = 0;
   int          cyc = 0;
   int          seed = 35136;
   int          n_flush = 0;
   int          n_fault = 0;
   int          x_flush = 0;
   int          x_fault = 0;
   int          n_iss = 0;
   logic [31:0] rf [16];
   logic [3:0]  fl = '0;
   logic        sticky = 1'b0;
   logic        rsv = 1'b0;
   logic        fen = 1'b0;

   always #20 pclk = ~pclk;

   exec_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr(instr),
      .instr_ready(instr_ready), .mem_req(mem_req),
      .mem_req_ready(mem_req_ready), .mem_rsp(mem_rsp),
      .mem_idle(mem_idle), .maint_busy(maint_busy),
      .fetch_flush(fetch_flush), .fatal_fault(fatal_fault));

   mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
      .mem_req_ready(mem_req_ready), .mem_rsp(mem_rsp),
      .mem_idle(mem_idle));

   // pulses counted each cycle, a hang cut off
   always @(posedge pclk)
   begin
      cyc++;
      if (fatal_fault === 1'b1) n_fault++;
      if (fetch_flush === 1'b1) n_flush++;
      if (cyc == 40000)
      begin
         err_count++;
         stop_test();
      end
   end

   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wreg(input int i, input logic [31:0] v);
      logic [31:0] q;
      logic        e;
      apb(1'b1, 8'h40 + 8'(4 * i), v, q, e);
      rf[i] = v;
   endtask

   // offer held until ready; k counts the stalled cycles afterwards
   task automatic issue(input logic w, input logic it, input logic [31:0] d,
      output int k);
      @(posedge pclk);
      instr <= {1'b1, w, it, d};
      do @(negedge pclk); while (instr_ready !== 1'b1);
      @(posedge pclk);
      instr.valid <= 1'b0;
      k = 0;
      n_iss++;
      @(negedge pclk);
      while (instr_ready !== 1'b1)
      begin
         k++;
         @(negedge pclk);
      end
   endtask

   function automatic logic [3:0] sub_flags(input logic [31:0] a, b);
      logic [32:0] s;
      s = {1'b0, a} + {1'b0, ~b} + 33'h1;
      return {s[31], s[31:0] == 32'h0, s[32], (a[31] ^ b[31]) & (s[31] ^ a[31])};
   endfunction

   task automatic ld(input logic [31:0] a, output logic ok, output logic [31:0] v);
      ok = a[31:28] != 4'hE;
      v = a ^ 32'h5A5AC3C3;
      if (!ok) x_fault++;
      if (!ok) sticky = 1'b1;
   endtask

   task automatic load_multiple_inc_after(input logic [2:0] n, input logic [7:0] lst);
      logic [31:0] a, v;
      logic        ok;
      a = rf[n];
      ok = 1'b1;
      for (int i = 0; i < 8; i++)
         if (lst[i] && ok)
         begin
            ld(a, ok, v);
            if (ok) rf[i] = v;
            a = a + WORD_STEP;
         end
      if (ok && !lst[n]) rf[n] = a;
   endtask

   task automatic chk_state;
      logic [31:0] q;
      logic        e;
      for (int i = 0; i < 16; i++)
      begin
         apb(1'b0, 8'h40 + 8'(4 * i), '0, q, e);
         chk(q, rf[i]);
      end
      apb(1'b0, FLAGS_ADDR, '0, q, e);
      chk({28'h0, q[31:28]}, {28'h0, fl});
      apb(1'b0, STAT_ADDR, '0, q, e);
      chk({28'h0, q[3:0]}, {28'h0, rsv, fen, sticky, 1'b0});
      apb(1'b0, COUNT_ADDR, '0, q, e);
      chk(q, 32'(n_iss - x_fault));
      chk(32'(n_fault), 32'(x_fault));
      chk(32'(n_flush), 32'(x_flush));
   endtask

   initial
   begin
      logic [31:0] q, r, v;
      logic [15:0] d;
      logic        e, ok, it;
      logic [3:0]  n4, mm, m4, o;
      logic [7:0]  lst;
      int          t, k, c;
      for (int i = 0; i < 16; i++) rf[i] = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      chk_state();
      apb(1'b0, 8'h10, '0, q, e);
      chk({31'h0, e}, 32'h1);
      $display("test reset done");
      for (int i = 0; i < 16; i++) wreg(i, $random(seed));
      apb(1'b1, CTRL_ADDR, 32'h1, q, e);
      // mixed operations on random operands, checked after each
      for (t = 0; t < 70; t++)
      begin
         r = $random(seed);
         it = r[12];
         m4 = (r[6:3] == 4'hF) ? SP_IDX : r[6:3];
         n4 = r[7] ? m4 : SP_IDX;
         mm = r[7] ? SP_IDX : m4;
         case (t % 7)
            0:
            begin
               d = {OPC_CMP_LO, r[5:3], r[2:0]};
               fl = sub_flags(rf[r[2:0]], rf[r[5:3]]);
            end
            1:
            begin
               d = {OPC_CMP_HI, n4[3], mm, n4[2:0]};
               fl = sub_flags(rf[n4], rf[mm]);
            end
            2:
            begin
               d = {OPC_MOV, r[11], m4, r[10:8]};
               rf[{r[11], r[10:8]}] = rf[m4];
            end
            3:
            begin
               d = {OPC_EOR, r[5:3], r[2:0]};
               v = rf[r[2:0]] ^ rf[r[5:3]];
               rf[r[2:0]] = v;
               if (!it) fl[3:2] = {v[31], v == 32'h0};
            end
            4:
            begin
               d = {OPC_LDR_RN, r[10:6], r[5:3], r[2:0]};
               ld(rf[r[5:3]] + {r[10:6], 2'b00}, ok, v);
               if (ok) rf[r[2:0]] = v;
            end
            5:
            begin
               d = {OPC_LDR_SP, r[10:8], r[7:0]};
               ld(rf[SP_IDX] + {r[7:0], 2'b00}, ok, v);
               if (ok) rf[r[10:8]] = v;
            end
            default:
            begin
               lst = (r[7:0] == 8'h0) ? 8'h81 : r[7:0];
               d = {OPC_LDM, r[10:8], lst};
               load_multiple_inc_after(r[10:8], lst);
            end
         endcase
         issue(1'b0, it, {16'h0, d}, k);
         chk_state();
      end
      $display("test operations done");
      // load, fence, then a list whose third word is refused
      wreg(1, 32'hDFFFFFF8);
      ld(rf[SP_IDX], ok, v);
      if (ok) rf[2] = v;
      issue(1'b0, 1'b0, {16'h0, OPC_LDR_SP, 3'h2, 8'h00}, k);
      // memory still draining, so the fence must hold the next access
      issue(1'b1, 1'b0, {OPC_BAR_HW1, OPC_DMB, OPT_SYS4}, k);
      load_multiple_inc_after(3'h1, 8'hFF);
      issue(1'b0, 1'b0, {16'h0, OPC_LDM, 3'h1, 8'hFF}, k);
      chk_state();
      $display("test fault done");
      for (t = 0; t < 12; t++)
      begin
         c = t % 3;
         o = (t < 3) ? OPT_SYS4 : 4'($random(seed));
         if (o != OPT_SYS4) rsv = 1'b1;
         @(posedge pclk);
         maint_busy <= (c == 1);
         fork
            begin
               repeat (8) @(posedge pclk);
               maint_busy <= 1'b0;
            end
         join_none
         x_flush += (c == 2);
         if (c < 2) fen = (c == 0);
         issue(1'b1, 1'b0, {OPC_BAR_HW1,
            c == 0 ? OPC_DMB : c == 1 ? OPC_DSB : OPC_ISB, o}, k);
         if (c == 1) chk(32'(k >= 5), 32'h1);
         else chk(32'(k), 32'(c / 2));
         chk_state();
      end
      $display("test barriers done");
      apb(1'b1, CTRL_ADDR, 32'h3, q, e);
      sticky = 1'b0;
      chk_state();
      $display("test clear done");
      stop_test();
   end
endmodule
